/* File: common/mfi_pkg.sv */
// Constants shared by the module flag interrupt logic.
package mfi_pkg;

  // ---------------------------------------------------------------------------
  // Management byte map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_ALARM_A     = 8'h50;
  localparam logic [7:0] ADDR_ALARM_B     = 8'h51;
  localparam logic [7:0] ADDR_WARNING_A   = 8'h52;
  localparam logic [7:0] ADDR_WARNING_B   = 8'h53;
  localparam logic [7:0] ADDR_STATUS_FLAG = 8'h54;
  localparam logic [7:0] ADDR_EXT_FLAG    = 8'h55;
  localparam logic [7:0] ADDR_SUPPLY_ALM  = 8'h56;
  localparam logic [7:0] ADDR_SUPPLY_WRN  = 8'h57;
  localparam logic [7:0] ADDR_MASK_BASE   = 8'h58;
  localparam logic [7:0] ADDR_CTRL_STATUS = 8'h6E;
  localparam logic [7:0] ADDR_PATH_STATUS = 8'h6F;
  localparam int         FLAG_BYTES       = 8;

  // ---------------------------------------------------------------------------
  // Reset values and implemented bits
  // ---------------------------------------------------------------------------
  localparam logic [7:0] MASK_RESET       = 8'h00;
  localparam logic [7:0] SOFT_CTRL_RESET  = 8'h00;
  localparam logic [7:0] IMPL_MONITOR_A   = 8'hCF;
  localparam logic [7:0] IMPL_MONITOR_B   = 8'hFC;
  localparam logic [7:0] IMPL_ALL         = 8'hFF;
  localparam logic [7:0] IMPL_EXT         = 8'hE0;
  localparam logic [7:0] IMPL_NONE        = 8'h00;
  localparam logic [7:0] READ_UNMAPPED    = 8'h00;

  // ---------------------------------------------------------------------------
  // Control and status byte fields
  // ---------------------------------------------------------------------------
  localparam int BIT_TX_DIS_STATE   = 7;
  localparam int BIT_SOFT_TX_DIS    = 6;
  localparam int BIT_MODULE_NOT_READY_STATE   = 5;
  localparam int BIT_PDOWN_STATE    = 4;
  localparam int BIT_SOFT_PDOWN     = 3;
  localparam int BIT_INT_STATE      = 2;
  localparam int BIT_RX_LOSS_STATE  = 1;
  localparam int BIT_DATA_NOT_READY = 0;

  // ---------------------------------------------------------------------------
  // Monitored quantities and threshold slots
  // ---------------------------------------------------------------------------
  localparam int QTY_COUNT   = 6;
  localparam int QTY_TEMP    = 0;
  localparam int QTY_BIAS    = 1;
  localparam int QTY_TXPOW   = 2;
  localparam int QTY_RXPOW   = 3;
  localparam int QTY_AUX1    = 4;
  localparam int QTY_AUX2    = 5;
  localparam int LIM_COUNT   = 4;
  localparam int LIM_HI_ALM  = 0;
  localparam int LIM_LO_ALM  = 1;
  localparam int LIM_HI_WRN  = 2;
  localparam int LIM_LO_WRN  = 3;
  localparam logic [5:0] SIGNED_QTY_DEFAULT = 6'h31;

  // ---------------------------------------------------------------------------
  // Synchronised pin order
  // ---------------------------------------------------------------------------
  localparam int PIN_COUNT     = 12;
  localparam int PIN_TX_PATH_NOT_READY     = 0;
  localparam int PIN_TX_FAULT  = 1;
  localparam int PIN_TX_CRU    = 2;
  localparam int PIN_RX_PATH_NOT_READY     = 3;
  localparam int PIN_RX_LOSS   = 4;
  localparam int PIN_RX_CRU    = 5;
  localparam int PIN_MODULE_NOT_READY    = 6;
  localparam int PIN_PD_SUPPLY = 7;
  localparam int PIN_COOLER    = 8;
  localparam int PIN_WL_UNLOCK = 9;
  localparam int PIN_TX_DIS    = 10;
  localparam int PIN_PDOWN     = 11;

endpackage : mfi_pkg

/* File: logic/mfi_flag_byte.sv */
// One latched flag byte with clear-on-read and its interrupt mask.
`timescale 1ns/1ns
module mfi_flag_byte #(
  parameter logic [7:0] IMPL = 8'hFF
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // Conditions, clear and mask
  input  wire logic [7:0] cond,
  input  wire logic       clear,
  input  wire logic [7:0] mask,
  // Latched state
  output logic      [7:0] flags,
  output logic            pending
);

  // A condition in the clearing cycle survives the clear.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      flags <= 8'h00;
    end else begin
      flags <= ((clear ? 8'h00 : flags) | cond) & IMPL;
    end
  end

  assign pending = |(flags & ~mask);

endmodule : mfi_flag_byte

/* File: logic/mfi_pin_sync.sv */
// Three-stage synchroniser that accepts a change once two stages agree.
`timescale 1ns/1ns
module mfi_pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         nrst,
  // Pins and filtered levels
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Each bit moves only when the second and third stages agree.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      level <= '0;
    end else begin
      level <= (stage2 & ~(stage2 ^ stage3)) | (level & (stage2 ^ stage3));
    end
  end

endmodule : mfi_pin_sync

/* File: logic/mfi_top.sv */
// Flag latching, masking and interrupt pin logic of the module management block.
`timescale 1ns/1ns

module mfi_top
  import mfi_pkg::*;
#(
  parameter logic [5:0] SIGNED_QTY   = SIGNED_QTY_DEFAULT,
  parameter bit         EXT_FAULTS   = 1'b1,
  parameter bit         SOFT_CONTROL = 1'b1
) (
  // Clock and reset
  input  wire logic                                  clock,
  input  wire logic                                  nrst,
  // Byte access from the two-wire serial engine
  input  wire logic [7:0]                            acc_addr,
  input  wire logic                                  acc_rd,
  input  wire logic                                  acc_wr,
  input  wire logic [7:0]                            acc_wdata,
  output logic      [7:0]                            acc_rdata,
  output logic                                       acc_rvalid,
  // Monitor samples and limits
  input  wire logic                                  mon_sample,
  input  wire logic [QTY_COUNT-1:0][15:0]            mon_value,
  input  wire logic [QTY_COUNT-1:0][LIM_COUNT-1:0][15:0] mon_limit,
  input  wire logic [7:0]                            supply_alarm,
  input  wire logic [7:0]                            supply_warning,
  // Status pins from outside the clock domain
  input  wire logic                                  tx_path_not_ready,
  input  wire logic                                  tx_laser_fault,
  input  wire logic                                  tx_clock_recovery_unlock,
  input  wire logic                                  rx_path_not_ready,
  input  wire logic                                  rx_signal_loss,
  input  wire logic                                  rx_clock_recovery_unlock,
  input  wire logic                                  module_not_ready,
  input  wire logic                                  photodiode_supply_fault,
  input  wire logic                                  cooler_fault,
  input  wire logic                                  wavelength_unlock,
  input  wire logic                                  tx_disable_pin,
  input  wire logic                                  power_down_pin,
  // Outputs
  output logic                                       interrupt_n,
  output logic                                       tx_disable_out,
  output logic                                       power_down_out
);

  // ---------------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------------

  // True when a measurement lies beyond a limit in the given direction.
  function automatic logic beyond(input logic [15:0] value, input logic [15:0] limit,
                                  input logic is_high, input logic is_signed);
    logic [15:0] v;
    logic [15:0] l;
    v = {value[15] ^ is_signed, value[14:0]};
    l = {limit[15] ^ is_signed, limit[14:0]};
    beyond = is_high ? (v > l) : (v < l);
  endfunction : beyond

  // True when an address falls inside an eight-byte window.
  function automatic logic in_window(input logic [7:0] addr, input logic [7:0] base);
    logic [7:0] diff;
    diff = addr - base;
    in_window = (diff < 8'h08);
  endfunction : in_window

  // ---------------------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------------------

  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin_lvl;

  always_comb begin
    pin_raw                = '0;
    pin_raw[PIN_TX_PATH_NOT_READY]     = tx_path_not_ready;
    pin_raw[PIN_TX_FAULT]  = tx_laser_fault;
    pin_raw[PIN_TX_CRU]    = tx_clock_recovery_unlock;
    pin_raw[PIN_RX_PATH_NOT_READY]     = rx_path_not_ready;
    pin_raw[PIN_RX_LOSS]   = rx_signal_loss;
    pin_raw[PIN_RX_CRU]    = rx_clock_recovery_unlock;
    pin_raw[PIN_MODULE_NOT_READY]    = module_not_ready;
    pin_raw[PIN_PD_SUPPLY] = photodiode_supply_fault;
    pin_raw[PIN_COOLER]    = cooler_fault;
    pin_raw[PIN_WL_UNLOCK] = wavelength_unlock;
    pin_raw[PIN_TX_DIS]    = tx_disable_pin;
    pin_raw[PIN_PDOWN]     = power_down_pin;
  end

  mfi_pin_sync #(
    .W (PIN_COUNT)
  ) u_pin_sync (
    .clock (clock),
    .nrst  (nrst),
    .pin   (pin_raw),
    .level (pin_lvl)
  );

  // ---------------------------------------------------------------------------
  // Reset complete event and data-ready tracking
  // ---------------------------------------------------------------------------

  logic reset_seen;
  logic data_not_ready;

  // One cycle after reset release the reset-complete event fires once.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      reset_seen <= 1'b0;
    end else begin
      reset_seen <= 1'b1;
    end
  end

  // Stays high until the first monitor sample arrives.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      data_not_ready <= 1'b1;
    end else if (mon_sample) begin
      data_not_ready <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Monitor threshold comparison
  // ---------------------------------------------------------------------------

  logic [QTY_COUNT-1:0] alm_hi;
  logic [QTY_COUNT-1:0] alm_lo;
  logic [QTY_COUNT-1:0] wrn_hi;
  logic [QTY_COUNT-1:0] wrn_lo;

  // A sample beyond a limit raises its flag on the sample edge only.
  for (genvar q = 0; q < QTY_COUNT; q++) begin : g_qty
    assign alm_hi[q] = mon_sample & beyond(mon_value[q], mon_limit[q][LIM_HI_ALM], 1'b1, SIGNED_QTY[q]);
    assign alm_lo[q] = mon_sample & beyond(mon_value[q], mon_limit[q][LIM_LO_ALM], 1'b0, SIGNED_QTY[q]);
    assign wrn_hi[q] = mon_sample & beyond(mon_value[q], mon_limit[q][LIM_HI_WRN], 1'b1, SIGNED_QTY[q]);
    assign wrn_lo[q] = mon_sample & beyond(mon_value[q], mon_limit[q][LIM_LO_WRN], 1'b0, SIGNED_QTY[q]);
  end

  // ---------------------------------------------------------------------------
  // Flag byte conditions
  // ---------------------------------------------------------------------------

  // Reserved positions are tied low here and cut again by the implemented-bit table.
  logic [7:0] cond [FLAG_BYTES];

  always_comb begin
    cond[0] = {alm_hi[QTY_TEMP], alm_lo[QTY_TEMP], 2'b00,
               alm_hi[QTY_BIAS], alm_lo[QTY_BIAS],
               alm_hi[QTY_TXPOW], alm_lo[QTY_TXPOW]};
    cond[1] = {alm_hi[QTY_RXPOW], alm_lo[QTY_RXPOW],
               alm_hi[QTY_AUX1], alm_lo[QTY_AUX1],
               alm_hi[QTY_AUX2], alm_lo[QTY_AUX2], 2'b00};
    cond[2] = {wrn_hi[QTY_TEMP], wrn_lo[QTY_TEMP], 2'b00,
               wrn_hi[QTY_BIAS], wrn_lo[QTY_BIAS],
               wrn_hi[QTY_TXPOW], wrn_lo[QTY_TXPOW]};
    cond[3] = {wrn_hi[QTY_RXPOW], wrn_lo[QTY_RXPOW],
               wrn_hi[QTY_AUX1], wrn_lo[QTY_AUX1],
               wrn_hi[QTY_AUX2], wrn_lo[QTY_AUX2], 2'b00};
    cond[4] = {pin_lvl[PIN_TX_PATH_NOT_READY], pin_lvl[PIN_TX_FAULT], pin_lvl[PIN_TX_CRU],
               pin_lvl[PIN_RX_PATH_NOT_READY], pin_lvl[PIN_RX_LOSS], pin_lvl[PIN_RX_CRU],
               pin_lvl[PIN_MODULE_NOT_READY], ~reset_seen};
    cond[5] = {pin_lvl[PIN_PD_SUPPLY], pin_lvl[PIN_COOLER],
               pin_lvl[PIN_WL_UNLOCK], 5'b0_0000};
    cond[6] = supply_alarm;
    cond[7] = supply_warning;
  end

  // ---------------------------------------------------------------------------
  // Latched flag bytes and masks
  // ---------------------------------------------------------------------------

  localparam logic [7:0] IMPL_TABLE [FLAG_BYTES] = '{
    IMPL_MONITOR_A, IMPL_MONITOR_B, IMPL_MONITOR_A, IMPL_MONITOR_B,
    IMPL_ALL, (EXT_FAULTS ? IMPL_EXT : IMPL_NONE), IMPL_ALL, IMPL_ALL
  };

  logic [7:0]            flags [FLAG_BYTES];
  logic [7:0]            mask  [FLAG_BYTES];
  logic [FLAG_BYTES-1:0] pending;
  logic [FLAG_BYTES-1:0] clear;
  logic                  rd_flag;
  logic                  wr_mask;
  logic [2:0]            acc_index;

  // Reads of flag bytes clear them; in this window writes reach only the mask bytes, never the flag bytes.
  assign rd_flag   = acc_rd & in_window(acc_addr, ADDR_ALARM_A);
  assign wr_mask   = acc_wr & in_window(acc_addr, ADDR_MASK_BASE);
  assign acc_index = acc_addr[2:0];

  for (genvar b = 0; b < FLAG_BYTES; b++) begin : g_flag
    assign clear[b] = rd_flag & (acc_index == 3'(b));

    mfi_flag_byte #(
      .IMPL (IMPL_TABLE[b])
    ) u_flag (
      .clock   (clock),
      .nrst    (nrst),
      .cond    (cond[b]),
      .clear   (clear[b]),
      .mask    (mask[b]),
      .flags   (flags[b]),
      .pending (pending[b])
    );

    // Masks are volatile and start unmasked.
    always_ff @(posedge clock) begin
      if (!nrst) begin
        mask[b] <= MASK_RESET;
      end else if (wr_mask && (acc_index == 3'(b))) begin
        mask[b] <= acc_wdata & IMPL_TABLE[b];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt pin
  // ---------------------------------------------------------------------------

  // Pin is the NOR of every latched flag gated by its inverted mask.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      interrupt_n <= 1'b1;
    end else begin
      interrupt_n <= ~(|pending);
    end
  end

  // ---------------------------------------------------------------------------
  // Soft control bits
  // ---------------------------------------------------------------------------

  logic soft_tx_disable;
  logic soft_power_down;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      soft_tx_disable <= SOFT_CTRL_RESET[BIT_SOFT_TX_DIS];
      soft_power_down <= SOFT_CTRL_RESET[BIT_SOFT_PDOWN];
    end else if (SOFT_CONTROL && acc_wr && (acc_addr == ADDR_CTRL_STATUS)) begin
      soft_tx_disable <= acc_wdata[BIT_SOFT_TX_DIS];
      soft_power_down <= acc_wdata[BIT_SOFT_PDOWN];
    end
  end

  // The soft transmit disable is ORed with the synchronised pin.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      tx_disable_out <= 1'b0;
    end else begin
      tx_disable_out <= pin_lvl[PIN_TX_DIS] | soft_tx_disable;
    end
  end

  // Power-down follows the soft bit alone; the pin is only reported in the status byte.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      power_down_out <= 1'b0;
    end else begin
      power_down_out <= soft_power_down;
    end
  end

  // ---------------------------------------------------------------------------
  // Live status bytes
  // ---------------------------------------------------------------------------

  // Both status bytes show live levels; only the soft bits and the data-not-ready bit are held.
  logic [7:0] ctrl_status;
  logic [7:0] path_status;

  always_comb begin
    ctrl_status                     = 8'h00;
    ctrl_status[BIT_TX_DIS_STATE]   = pin_lvl[PIN_TX_DIS];
    ctrl_status[BIT_SOFT_TX_DIS]    = soft_tx_disable;
    ctrl_status[BIT_MODULE_NOT_READY_STATE]   = pin_lvl[PIN_MODULE_NOT_READY];
    ctrl_status[BIT_PDOWN_STATE]    = pin_lvl[PIN_PDOWN];
    ctrl_status[BIT_SOFT_PDOWN]     = soft_power_down;
    ctrl_status[BIT_INT_STATE]      = interrupt_n;
    ctrl_status[BIT_RX_LOSS_STATE]  = pin_lvl[PIN_RX_LOSS];
    ctrl_status[BIT_DATA_NOT_READY] = data_not_ready;
    path_status = {pin_lvl[PIN_TX_PATH_NOT_READY], pin_lvl[PIN_TX_FAULT], pin_lvl[PIN_TX_CRU],
                   pin_lvl[PIN_RX_PATH_NOT_READY], pin_lvl[PIN_RX_CRU], 3'b000};
  end

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------

  logic [7:0] next_rdata;

  // The value returned is the one held before the read clears it.
  always_comb begin
    next_rdata = READ_UNMAPPED;
    if (in_window(acc_addr, ADDR_ALARM_A)) begin
      next_rdata = flags[acc_index];
    end else if (in_window(acc_addr, ADDR_MASK_BASE)) begin
      next_rdata = mask[acc_index];
    end else if (acc_addr == ADDR_CTRL_STATUS) begin
      next_rdata = ctrl_status;
    end else if (acc_addr == ADDR_PATH_STATUS) begin
      next_rdata = path_status;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      acc_rvalid <= 1'b0;
    end else begin
      acc_rvalid <= acc_rd;
    end
  end

  // Read data stands until the next read.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      acc_rdata <= 8'h00;
    end else if (acc_rd) begin
      acc_rdata <= next_rdata;
    end
  end

endmodule : mfi_top

/* File: sim/mfi_host_model.sv */
// Host side of the byte access path: single writes and block reads.
`timescale 1ns/1ns
module mfi_host_model
  import mfi_pkg::*;
(
  // Clock
  input  wire logic       clock,
  // Byte access
  output logic      [7:0] acc_addr,
  output logic            acc_rd,
  output logic            acc_wr,
  output logic      [7:0] acc_wdata,
  input  wire logic [7:0] acc_rdata,
  input  wire logic       acc_rvalid
);
  initial begin
    acc_addr  = 8'h00;
    acc_rd    = 1'b0;
    acc_wr    = 1'b0;
    acc_wdata = 8'h00;
  end

  // Idle address and data are inverted so that no stale value can pass for a request.
  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    acc_addr  = a;
    acc_wdata = d;
    acc_wr    = 1'b1;
    @(negedge clock);
    acc_wr    = 1'b0;
    acc_addr  = ~a;
    acc_wdata = ~d;
  endtask : write_byte

  // Consecutive bytes are read back to back in one operation.
  task automatic read_block(input logic [7:0] a, input int n, output logic [63:0] d);
    d = 64'h0000_0000_0000_0000;
    @(negedge clock);
    acc_rd = 1'b1;
    for (int i = 0; i < n; i++) begin
      acc_addr = a + 8'(i);
      @(negedge clock);
      // A read with no answer leaves unknown bits that fail the comparison.
      d[8*i+:8] = acc_rvalid ? acc_rdata : 8'hxx;
    end
    acc_rd   = 1'b0;
    acc_addr = ~acc_addr;
  endtask : read_block
endmodule : mfi_host_model

/* File: sim/mfi_props.sv */
// Concurrent checks on the ports of the flag interrupt block.
`timescale 1ns/1ns
module mfi_props
  import mfi_pkg::*;
(
  // Clock and reset
  input wire logic       clock,
  input wire logic       nrst,
  // Byte access and outputs
  input wire logic [7:0] acc_addr,
  input wire logic       acc_rd,
  input wire logic       acc_wr,
  input wire logic [7:0] acc_wdata,
  input wire logic [7:0] acc_rdata,
  input wire logic       acc_rvalid,
  input wire logic       interrupt_n,
  input wire logic       tx_disable_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  logic unmapped;
  assign unmapped = (acc_addr < ADDR_ALARM_A) || (acc_addr > 8'h5F && acc_addr < ADDR_CTRL_STATUS) || (acc_addr > 8'h6F);

  rvalid_after_read_a: assert property (acc_rd |=> acc_rvalid)
    else $error("read not answered in the next cycle");
  rvalid_has_cause_a: assert property (acc_rvalid |-> $past(acc_rd))
    else $error("read answer without a read");
  rdata_holds_a: assert property (!acc_rd |=> $stable(acc_rdata))
    else $error("read data changed without a read");
  reset_flag_irq_a: assert property ($rose(nrst) |-> ##2 !interrupt_n)
    else $error("reset complete did not raise the interrupt");
  unmapped_zero_a: assert property ((acc_rd && unmapped) |=> acc_rdata == READ_UNMAPPED)
    else $error("unmapped read not zero");
  reserved_zero_a: assert property ((acc_rd && (acc_addr == ADDR_ALARM_A || acc_addr == ADDR_WARNING_A))
    |=> acc_rdata[5:4] == 2'h0)
    else $error("reserved flag bits not zero");
  release_cause_a: assert property (($rose(interrupt_n) && $past(nrst)) |-> ($past(acc_rvalid) || $past(acc_wr, 2)))
    else $error("interrupt released without a read or mask write");
  irq_status_bit_a: assert property ((acc_rd && acc_addr == ADDR_CTRL_STATUS)
    |=> acc_rdata[BIT_INT_STATE] == $past(interrupt_n))
    else $error("status byte does not show the interrupt level");
  soft_txdis_a: assert property ((acc_wr && acc_addr == ADDR_CTRL_STATUS && acc_wdata[BIT_SOFT_TX_DIS])
    |-> ##[1:3] tx_disable_out)
    else $error("soft transmit disable had no effect");

  cover property (acc_rd && acc_addr == ADDR_STATUS_FLAG);
  cover property ($rose(interrupt_n));
  cover property (acc_wr && acc_addr >= ADDR_MASK_BASE);
endmodule : mfi_props

bind mfi_top mfi_props i_mfi_props (.clock(clock), .nrst(nrst), .acc_addr(acc_addr), .acc_rd(acc_rd),
  .acc_wr(acc_wr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid),
  .interrupt_n(interrupt_n), .tx_disable_out(tx_disable_out));

/* File: sim/mfi_top_bench.sv */
// Self-checking bench for the flag latching and interrupt block.
`timescale 1ns/1ns
module mfi_top_bench
  import mfi_pkg::*;
;
  logic                                      clock, nrst, acc_rd, acc_wr, acc_rvalid, mon_sample;
  logic                                      interrupt_n, tx_disable_out, power_down_out;
  logic [7:0]                                acc_addr, acc_wdata, acc_rdata, supply_alarm, supply_warning;
  logic [QTY_COUNT-1:0][15:0]                mon_value;
  logic [QTY_COUNT-1:0][LIM_COUNT-1:0][15:0] mon_limit;
  logic [15:0]                               pv, e16;
  logic [63:0]                               got, want;
  int                                        err_total, cmp_count, sh;
  int                                        pos [6] = '{7, 3, 1, 7, 5, 3};

  mfi_top i_mfi_top (.clock(clock), .nrst(nrst), .acc_addr(acc_addr), .acc_rd(acc_rd), .acc_wr(acc_wr),
    .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid), .mon_sample(mon_sample),
    .mon_value(mon_value), .mon_limit(mon_limit), .supply_alarm(supply_alarm), .supply_warning(supply_warning),
    .tx_path_not_ready(pv[7]), .tx_laser_fault(pv[6]), .tx_clock_recovery_unlock(pv[5]),
    .rx_path_not_ready(pv[4]), .rx_signal_loss(pv[3]), .rx_clock_recovery_unlock(pv[2]),
    .module_not_ready(pv[1]), .photodiode_supply_fault(pv[15]), .cooler_fault(pv[14]),
    .wavelength_unlock(pv[13]), .tx_disable_pin(pv[8]), .power_down_pin(pv[9]), .interrupt_n(interrupt_n),
    .tx_disable_out(tx_disable_out), .power_down_out(power_down_out));
  mfi_host_model i_mfi_host_model (.clock(clock), .acc_addr(acc_addr), .acc_rd(acc_rd), .acc_wr(acc_wr),
    .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid));

  // ---------------------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------------------
  task automatic check(input logic [63:0] g, input logic [63:0] w);
    cmp_count++;
    if (g !== w) begin
      err_total++;
      $display("ERROR t=%0t got %h want %h", $time, g, w);
    end
  endtask : check

  task automatic stop_test;
    $display("TB: %0d mismatches in %0d comparisons", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial begin
    repeat (40000) @(posedge clock);
    err_total++;
    $display("ERROR t=%0t run did not finish", $time);
    stop_test();
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    err_total = 0;
    cmp_count = 0;
    nrst = 1'b0;
    mon_sample = 1'b0;
    pv = 16'h0000;
    supply_alarm = 8'h00;
    supply_warning = 8'h00;
    for (int q = 0; q < QTY_COUNT; q++) begin
      mon_limit[q] = {16'h00C8, 16'h0320, 16'h0064, 16'h03E8};
      mon_value[q] = 16'h01F4;
    end
    repeat (2) @(negedge clock);
    nrst = 1'b1;
    repeat (3) @(negedge clock);
    check(64'(interrupt_n), 64'h0000_0000_0000_0000);
    i_mfi_host_model.read_block(ADDR_ALARM_A, FLAG_BYTES, got);
    check(got, 64'h0000_0001_0000_0000);
    repeat (3) @(negedge clock);
    check(64'(interrupt_n), 64'h0000_0000_0000_0001);
    i_mfi_host_model.read_block(ADDR_MASK_BASE, FLAG_BYTES, got);
    check(got, 64'h0000_0000_0000_0000);
    for (int k = 1; k < 16; k++) begin
      if (k inside {[8:12]}) continue;
      e16 = 16'h0001 << k;
      pv = e16;
      repeat (6) @(negedge clock);
      check(64'(interrupt_n), 64'h0000_0000_0000_0000);
      pv = 16'h0000;
      repeat (6) @(negedge clock);
      i_mfi_host_model.read_block(ADDR_ALARM_A, FLAG_BYTES, got);
      check(got, {16'h0000, e16, 32'h0000_0000});
    end
    for (int q = 0; q < QTY_COUNT; q++) begin
      for (int lo = 0; lo < 2; lo++) begin
        mon_value[q] = (lo == 1) ? (SIGNED_QTY_DEFAULT[q] ? 16'hFF00 : 16'h0032)
                                 : (SIGNED_QTY_DEFAULT[q] ? 16'h044C : 16'hFF00);
        mon_sample = 1'b1;
        @(negedge clock);
        mon_sample = 1'b0;
        mon_value[q] = 16'h01F4;
        sh = (q < 3 ? 0 : 8) + pos[q] - lo;
        want = (64'h0000_0000_0000_0001 << sh) | (64'h0000_0000_0000_0001 << (sh + 16));
        i_mfi_host_model.read_block(ADDR_ALARM_A, FLAG_BYTES, got);
        check(got, want);
      end
    end
    supply_alarm = 8'h01;
    supply_warning = 8'h80;
    i_mfi_host_model.write_byte(ADDR_MASK_BASE + 8'h06, 8'h01);
    i_mfi_host_model.write_byte(ADDR_MASK_BASE + 8'h07, 8'h80);
    i_mfi_host_model.read_block(ADDR_ALARM_A, FLAG_BYTES, got);
    check(got, 64'h8001_0000_0000_0000);
    repeat (3) @(negedge clock);
    check(64'(interrupt_n), 64'h0000_0000_0000_0001);
    i_mfi_host_model.write_byte(ADDR_MASK_BASE + 8'h06, 8'h00);
    repeat (3) @(negedge clock);
    check(64'(interrupt_n), 64'h0000_0000_0000_0000);
    supply_alarm = 8'h00;
    supply_warning = 8'h00;
    i_mfi_host_model.write_byte(ADDR_ALARM_A, 8'hFF);
    i_mfi_host_model.read_block(ADDR_ALARM_A, FLAG_BYTES, got);
    check(got, 64'h8001_0000_0000_0000);
    repeat (3) @(negedge clock);
    check(64'(interrupt_n), 64'h0000_0000_0000_0001);
    i_mfi_host_model.write_byte(ADDR_MASK_BASE, 8'hFF);
    i_mfi_host_model.write_byte(ADDR_MASK_BASE + 8'h01, 8'hFF);
    i_mfi_host_model.read_block(ADDR_MASK_BASE, FLAG_BYTES, got);
    check(got, 64'h8000_0000_0000_FCCF);
    pv = 16'h0100;
    repeat (6) @(negedge clock);
    check(64'({tx_disable_out, power_down_out}), 64'h0000_0000_0000_0002);
    i_mfi_host_model.write_byte(ADDR_CTRL_STATUS, 8'hFF);
    repeat (3) @(negedge clock);
    check(64'({tx_disable_out, power_down_out}), 64'h0000_0000_0000_0003);
    pv = 16'h0382;
    repeat (6) @(negedge clock);
    i_mfi_host_model.read_block(ADDR_CTRL_STATUS, 2, got);
    check(got, 64'h0000_0000_0000_80F8);
    i_mfi_host_model.read_block(8'h10, 1, got);
    check(got, 64'h0000_0000_0000_0000);
    stop_test();
  end
endmodule : mfi_top_bench
